// file: rtl/cfgrl_cfg.svh
/*
  Constants of the configuration register and latency block: register
  addresses, field positions, reset values and command opcodes.
  Assumes it is included by bare name wherever these values are used.
*/
`ifndef CFGRL_CFG_SVH
`define CFGRL_CFG_SVH

// =====================================================================
// Register addresses on the serial link.
`define CFGRL_ADDR_CFG1_NV   24'h000002
`define CFGRL_ADDR_CFG1_V    24'h070002
`define CFGRL_ADDR_STS2_NV   24'h000001
`define CFGRL_ADDR_STS2_V    24'h070001

// =====================================================================
// Field layout and reset values.
`define CFGRL_CFG1_RESET     8'h00
`define CFGRL_CFG1_MASK      8'hf2
`define CFGRL_MLC_MSB        7
`define CFGRL_MLC_LSB        4
`define CFGRL_QUAD_BIT       1
`define CFGRL_CRC_ABORT_FLAG_BIT       3
`define CFGRL_CRC_MIN_SPAN   25'h0000003

// =====================================================================
// Command opcodes.
`define CFGRL_OP_WR_ENABLE   8'h06
`define CFGRL_OP_WR_DISABLE  8'h04
`define CFGRL_OP_WR_ANY      8'h71
`define CFGRL_OP_RD_ANY      8'h65
`define CFGRL_OP_RD_CFG1     8'h35
`define CFGRL_OP_RD_STS2     8'h07
`define CFGRL_OP_CRC_CALC    8'h5b
`define CFGRL_OP_RST_ENABLE  8'h66
`define CFGRL_OP_RST         8'h99
`define CFGRL_OP_RD_PLAIN    8'h03
`define CFGRL_OP_RD_FAST     8'h0b
`define CFGRL_OP_RD_SPECIAL  8'h4b
`define CFGRL_OP_RD_DUAL_OUT 8'h3b
`define CFGRL_OP_RD_DUAL_IO  8'hbb
`define CFGRL_OP_RD_QUAD_OUT 8'h6b
`define CFGRL_OP_RD_QUAD_IO  8'heb

`endif

// file: rtl/cfgrl_pkg.sv
/*
  Types shared by the configuration register and latency block.
  Assumes nothing of its surroundings; no file imports it.
*/
package cfgrl_pkg;

  // ===================================================================
  // Link state machine states.
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_END_ADDR, ST_WDATA, ST_DUMMY, ST_RDATA, ST_IGNORE
  } cfgrl_state_t;

  // ===================================================================
  // Events passed from the link to the register bank.
  typedef enum logic [3:0] {
    EV_NONE, EV_WR_ENABLE, EV_WR_DISABLE, EV_WRITE_NV, EV_WRITE_V,
    EV_CRC_OK, EV_CRC_ABORT, EV_RST_ENABLE, EV_RST
  } cfgrl_ev_kind_t;

  typedef struct packed {
    cfgrl_ev_kind_t kind;
    logic [7:0]     data;
  } cfgrl_event_t;

  // Settings published from the register bank to the link.
  typedef struct packed {
    logic       crc_abort;
    logic [7:0] cfg;
  } cfgrl_pub_t;

endpackage : cfgrl_pkg

// file: rtl/cfgrl_sync.sv
/*
  Two-stage synchroniser for a level or a word that is held stable.
  Assumes the destination clock on clk_i and a synchronous low reset.
*/
`timescale 1ns/1ns
`default_nettype none

module cfgrl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // =====================================================================
  // The first stage is read by the second stage only.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule : cfgrl_sync

`default_nettype wire

// file: rtl/cfgrl_reg_bank.sv
/*
  Register bank on the system clock: both copies of configuration
  register one, the write enable latch and the CRC abort flag.
  Assumes one-cycle event pulses whose word is stable while valid.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cfgrl_cfg.svh"

module cfgrl_reg_bank (
  input  wire logic                  mclk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  hw_reset_i,
  input  wire logic                  idle_i,
  input  wire logic                  ev_valid_i,
  input  wire cfgrl_pkg::cfgrl_event_t ev_i,
  output logic [7:0]                 cfg_o,
  output logic                       crc_abort_o,
  output cfgrl_pkg::cfgrl_pub_t      pub_o
);

  logic [7:0] config_one_nonvolatile_reg;
  logic       write_enable_latch_reg;
  logic       rst_armed_reg;
  logic       wr_ok;
  logic       sw_reset;

  // Register writes are honoured only while the latch is set.
  assign wr_ok    = ev_valid_i && write_enable_latch_reg; // RULE20
  assign sw_reset = ev_valid_i && (ev_i.kind == cfgrl_pkg::EV_RST) &&
                    rst_armed_reg;

  // =====================================================================
  // Nonvolatile copy, changed only by a nonvolatile write.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      config_one_nonvolatile_reg <= `CFGRL_CFG1_RESET;
    end else if (wr_ok && ev_i.kind == cfgrl_pkg::EV_WRITE_NV) begin
      config_one_nonvolatile_reg <= ev_i.data & `CFGRL_CFG1_MASK; // RULE21
    end
  end

  // Volatile copy: reloaded on hardware reset, written by both kinds.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cfg_o <= `CFGRL_CFG1_RESET; // RULE4
    end else if (hw_reset_i) begin
      cfg_o <= config_one_nonvolatile_reg; // RULE4
    end else if (wr_ok && (ev_i.kind == cfgrl_pkg::EV_WRITE_NV ||
                           ev_i.kind == cfgrl_pkg::EV_WRITE_V)) begin
      cfg_o <= ev_i.data & `CFGRL_CFG1_MASK; // RULE6 RULE7 RULE21
    end
  end

  // =====================================================================
  // Write enable latch, cleared by any write attempt to configuration register one.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || hw_reset_i || sw_reset) begin
      write_enable_latch_reg <= 1'b0;
    end else if (ev_valid_i) begin
      case (ev_i.kind)
        cfgrl_pkg::EV_WR_ENABLE:  write_enable_latch_reg <= 1'b1;
        cfgrl_pkg::EV_WR_DISABLE,
        cfgrl_pkg::EV_WRITE_NV,
        cfgrl_pkg::EV_WRITE_V:    write_enable_latch_reg <= 1'b0;
        default: write_enable_latch_reg <= write_enable_latch_reg;
      endcase
    end
  end

  // Software reset needs the enable command just before it.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rst_armed_reg <= 1'b0;
    end else if (ev_valid_i) begin
      rst_armed_reg <= (ev_i.kind == cfgrl_pkg::EV_RST_ENABLE);
    end
  end

  // =====================================================================
  // CRC abort flag: set by a failed range check, cleared by a good one.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || hw_reset_i || sw_reset) begin
      crc_abort_o <= 1'b0; // RULE3
    end else if (ev_valid_i && ev_i.kind == cfgrl_pkg::EV_CRC_ABORT) begin
      crc_abort_o <= 1'b1; // RULE1
    end else if (ev_valid_i && ev_i.kind == cfgrl_pkg::EV_CRC_OK) begin
      crc_abort_o <= 1'b0; // RULE2
    end
  end

  // Published copy changes only while no frame is open.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pub_o <= '0;
    end else if (idle_i) begin
      pub_o <= '{crc_abort: crc_abort_o, cfg: cfg_o}; // RULE5
    end
  end

endmodule : cfgrl_reg_bank

`default_nettype wire

// file: rtl/cfgrl_top.sv
/*
  Top of the configuration register and latency block: serial link
  slave on the serial clock, and the register bank on the system clock.
  Assumes mode 0 timing: the host shifts in on the falling edge of
  sck_i and samples on the rising edge; the serial clock runs only
  while chip select is low, and chip select stays high for at least
  four system clock cycles between frames.
*/
// Summary of operation
// (RULE1) Abort CRC, set flag when end below start+3.
// (RULE2) Successful CRC start clears abort flag.
// (RULE3) Any reset clears the abort flag.
// (RULE4) Reset reloads volatile copy from nonvolatile copy; code reloads on hardware reset only, not software reset.
// (RULE5) Logic uses only the volatile settings.
// (RULE6) Volatile write changes volatile copy only.
// (RULE7) Nonvolatile write changes both copies.
// (RULE8) Register reads return the volatile copy.
// (RULE9) Nonvolatile and volatile addresses; reads accept both.
// (RULE10) Write via any-register write; read two ways.
// (RULE11) Bits 7 to 4 give dummy cycles directly.
// (RULE12) Latency applies to memory and special reads.
// (RULE13) Each dummy cycle is one full clock.
// (RULE14) Dummy cycles follow address; then data.
// (RULE15) Host picks latency fit for its clock.
// (RULE16) Phases use the lane counts of format.
// (RULE17) Mode byte cycles lie inside the latency.
// (RULE18) Bit 1 selects four-lane operation.
// (RULE19) Four lanes: protect and reset pins carry data.
// (RULE20) Register writes need the write enable latch.
// (RULE21) Reserved bits read zero, writes ignored.
// (RULE22) Settings latch when a read command begins.
`timescale 1ns/1ns
`default_nettype none
`include "cfgrl_cfg.svh"

module cfgrl_top (
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_o,
  output logic      [3:0] latency_code_o,
  output logic            quad_enable_o,
  output logic            wp_level_o,
  output logic            crc_abort_o
);

  // =====================================================================
  // Helper functions.

  // Shifts lane bits into the low end of a word.
  function automatic logic [23:0] shift_in(input logic [23:0] v,
                                           input logic [3:0]  io,
                                           input logic [2:0]  lanes);
    case (lanes)
      3'd4:    shift_in = {v[19:0], io};
      3'd2:    shift_in = {v[21:0], io[1:0]};
      default: shift_in = {v[22:0], io[0]};
    endcase
  endfunction : shift_in

  // Last edge index of a phase of 8 or 24 bits.
  function automatic logic [4:0] last_cnt(input logic       wide,
                                          input logic [2:0] lanes);
    case (lanes)
      3'd4:    last_cnt = wide ? 5'd5 : 5'd1;
      3'd2:    last_cnt = wide ? 5'd11 : 5'd3;
      default: last_cnt = wide ? 5'd23 : 5'd7;
    endcase
  endfunction : last_cnt

  // Which register a link address selects.
  function automatic logic [1:0] reg_sel(input logic [23:0] a);
    if (a == `CFGRL_ADDR_CFG1_NV) begin
      reg_sel = 2'h1;
    end else if (a == `CFGRL_ADDR_CFG1_V) begin
      reg_sel = 2'h2;
    end else if (a == `CFGRL_ADDR_STS2_NV || a == `CFGRL_ADDR_STS2_V) begin
      reg_sel = 2'h3;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction : reg_sel

  // =====================================================================
  // Signals.
  cfgrl_pkg::cfgrl_state_t state_reg;
  cfgrl_pkg::cfgrl_event_t ev_reg;
  cfgrl_pkg::cfgrl_pub_t   pub_mclk;
  cfgrl_pkg::cfgrl_pub_t   pub_sck;
  cfgrl_pkg::cfgrl_event_t ev_word;
  logic        ev_flag_reg;
  logic [4:0]  cnt_reg;
  logic [7:0]  op_reg;
  logic [23:0] addr_reg;
  logic [23:0] start_reg;
  logic [7:0]  data_reg;
  logic [7:0]  rd_byte_reg;
  logic [3:0]  mlc_reg;
  logic        quad_reg;
  logic [2:0]  alanes_reg;
  logic [2:0]  dlanes_reg;
  logic [7:0]  op_now;
  logic [23:0] addr_now;
  logic [7:0]  byte_now;
  logic [7:0]  obyte;
  logic [7:0]  osh_reg;
  logic [2:0]  ocnt_reg;
  logic        cs_n_sync;
  logic [1:0]  pins_sync;
  logic        ev_flag_sync;
  logic        ev_seen_reg;
  logic        hw_reset;
  logic [7:0]  cfg_vol;

  assign op_now   = {op_reg[6:0], io_i[0]};
  assign addr_now = shift_in(addr_reg, io_i, alanes_reg);
  assign byte_now = 8'(shift_in({16'h0000, data_reg}, io_i, 3'd1));

  // =====================================================================
  // Link state machine on the serial clock, cleared by chip select.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      state_reg   <= cfgrl_pkg::ST_CMD;
      cnt_reg     <= 5'h00;
      op_reg      <= 8'h00;
      addr_reg    <= 24'h000000;
      start_reg   <= 24'h000000;
      data_reg    <= 8'h00;
      rd_byte_reg <= 8'h00;
      mlc_reg     <= 4'h0;
      quad_reg    <= 1'b0;
      alanes_reg  <= 3'd1;
      dlanes_reg  <= 3'd1;
      ev_reg      <= '{kind: cfgrl_pkg::EV_NONE, data: 8'h00};
      ev_flag_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 5'd1;
      case (state_reg)
        cfgrl_pkg::ST_CMD: begin
          op_reg <= op_now; // RULE16
          if (cnt_reg == 5'd7) begin
            cnt_reg  <= 5'h00;
            // Settings are frozen for the whole command.
            mlc_reg  <= pub_sck.cfg[`CFGRL_MLC_MSB:`CFGRL_MLC_LSB]; // RULE22
            quad_reg <= pub_sck.cfg[`CFGRL_QUAD_BIT]; // RULE22
            alanes_reg <= 3'd1;
            dlanes_reg <= 3'd1;
            state_reg  <= cfgrl_pkg::ST_ADDR;
            case (op_now)
              `CFGRL_OP_WR_ENABLE, `CFGRL_OP_WR_DISABLE,
              `CFGRL_OP_RST_ENABLE, `CFGRL_OP_RST: begin
                state_reg   <= cfgrl_pkg::ST_IGNORE;
                ev_flag_reg <= 1'b1;
                case (op_now)
                  `CFGRL_OP_WR_ENABLE:
                    ev_reg.kind <= cfgrl_pkg::EV_WR_ENABLE;
                  `CFGRL_OP_WR_DISABLE:
                    ev_reg.kind <= cfgrl_pkg::EV_WR_DISABLE;
                  `CFGRL_OP_RST_ENABLE:
                    ev_reg.kind <= cfgrl_pkg::EV_RST_ENABLE;
                  default:
                    ev_reg.kind <= cfgrl_pkg::EV_RST;
                endcase
              end
              `CFGRL_OP_RD_CFG1: begin
                state_reg   <= cfgrl_pkg::ST_RDATA;
                rd_byte_reg <= pub_sck.cfg; // RULE8 RULE10
              end
              `CFGRL_OP_RD_STS2: begin
                state_reg   <= cfgrl_pkg::ST_RDATA;
                rd_byte_reg <= 8'(pub_sck.crc_abort) << `CFGRL_CRC_ABORT_FLAG_BIT;
              end
              `CFGRL_OP_WR_ANY, `CFGRL_OP_RD_ANY, `CFGRL_OP_CRC_CALC,
              `CFGRL_OP_RD_PLAIN, `CFGRL_OP_RD_FAST,
              `CFGRL_OP_RD_SPECIAL: begin
                state_reg <= cfgrl_pkg::ST_ADDR; // RULE12
              end
              `CFGRL_OP_RD_DUAL_OUT: begin
                dlanes_reg <= 3'd2;
              end
              `CFGRL_OP_RD_DUAL_IO: begin
                alanes_reg <= 3'd2; // RULE16
                dlanes_reg <= 3'd2;
              end
              `CFGRL_OP_RD_QUAD_OUT, `CFGRL_OP_RD_QUAD_IO: begin
                // Quad reads run only with four lanes enabled.
                if (!pub_sck.cfg[`CFGRL_QUAD_BIT]) begin
                  state_reg <= cfgrl_pkg::ST_IGNORE; // RULE18
                end
                if (op_now == `CFGRL_OP_RD_QUAD_IO) begin
                  alanes_reg <= 3'd4;
                end
                dlanes_reg <= 3'd4; // RULE16
              end
              default: state_reg <= cfgrl_pkg::ST_IGNORE;
            endcase
          end
        end
        cfgrl_pkg::ST_ADDR: begin
          addr_reg <= addr_now;
          if (cnt_reg == last_cnt(1'b1, alanes_reg)) begin
            cnt_reg <= 5'h00;
            case (op_reg)
              `CFGRL_OP_WR_ANY: state_reg <= cfgrl_pkg::ST_WDATA; // RULE10
              `CFGRL_OP_CRC_CALC: begin
                start_reg <= addr_now;
                state_reg <= cfgrl_pkg::ST_END_ADDR;
              end
              `CFGRL_OP_RD_ANY: begin
                state_reg <= cfgrl_pkg::ST_RDATA;
                // Both addresses of register one read the volatile copy.
                case (reg_sel(addr_now))
                  2'h1, 2'h2: rd_byte_reg <= pub_sck.cfg; // RULE8 RULE9
                  2'h3: rd_byte_reg <=
                    8'(pub_sck.crc_abort) << `CFGRL_CRC_ABORT_FLAG_BIT;
                  default: rd_byte_reg <= 8'h00;
                endcase
              end
              default: begin
                // Memory reads: mode cycles are inside the latency.
                rd_byte_reg <= addr_now[7:0];
                if (mlc_reg == 4'h0) begin
                  state_reg <= cfgrl_pkg::ST_RDATA; // RULE11
                end else begin
                  state_reg <= cfgrl_pkg::ST_DUMMY; // RULE14 RULE17
                end
              end
            endcase
          end
        end
        cfgrl_pkg::ST_END_ADDR: begin
          addr_reg <= addr_now;
          if (cnt_reg == 5'd23) begin
            state_reg   <= cfgrl_pkg::ST_IGNORE;
            ev_flag_reg <= 1'b1;
            if ({1'b0, addr_now} < {1'b0, start_reg} + `CFGRL_CRC_MIN_SPAN)
            begin
              ev_reg.kind <= cfgrl_pkg::EV_CRC_ABORT; // RULE1
            end else begin
              ev_reg.kind <= cfgrl_pkg::EV_CRC_OK; // RULE2
            end
          end
        end
        cfgrl_pkg::ST_WDATA: begin
          data_reg <= byte_now;
          if (cnt_reg == 5'd7) begin
            state_reg   <= cfgrl_pkg::ST_IGNORE;
            ev_reg.data <= byte_now;
            case (reg_sel(addr_reg))
              2'h1: begin
                ev_reg.kind <= cfgrl_pkg::EV_WRITE_NV; // RULE7 RULE9
                ev_flag_reg <= 1'b1;
              end
              2'h2: begin
                ev_reg.kind <= cfgrl_pkg::EV_WRITE_V; // RULE6 RULE9
                ev_flag_reg <= 1'b1;
              end
              default: ev_flag_reg <= 1'b0;
            endcase
          end
        end
        cfgrl_pkg::ST_DUMMY: begin
          // One dummy cycle per full serial clock period.
          if (cnt_reg == 5'(mlc_reg) - 5'd1) begin
            state_reg <= cfgrl_pkg::ST_RDATA; // RULE13 RULE14
          end
        end
        cfgrl_pkg::ST_RDATA:  cnt_reg <= 5'h00;
        cfgrl_pkg::ST_IGNORE: cnt_reg <= 5'h00;
        default:              state_reg <= cfgrl_pkg::ST_IGNORE;
      endcase
    end
  end

  // =====================================================================
  // Read data driven on the falling edge, only in the data phase.
  assign obyte = (ocnt_reg == 3'd0) ? rd_byte_reg : osh_reg;

  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      io_o     <= 4'h0;
      io_oe_o  <= 4'h0;
      osh_reg  <= 8'h00;
      ocnt_reg <= 3'd0;
    end else if (state_reg == cfgrl_pkg::ST_RDATA) begin
      osh_reg  <= obyte << dlanes_reg;
      ocnt_reg <= (ocnt_reg == 3'(last_cnt(1'b0, dlanes_reg))) ?
                  3'd0 : ocnt_reg + 3'd1;
      case (dlanes_reg)
        3'd4: begin
          io_o    <= obyte[7:4]; // RULE16 RULE19
          io_oe_o <= 4'hf;
        end
        3'd2: begin
          io_o    <= {2'b00, obyte[7:6]};
          io_oe_o <= 4'h3;
        end
        default: begin
          io_o    <= {2'b00, obyte[7], 1'b0};
          io_oe_o <= 4'h2;
        end
      endcase
    end else begin
      io_oe_o <= 4'h0; // RULE14
      io_o    <= 4'h0;
    end
  end

  // =====================================================================
  // Crossings between the serial clock and the system clock.
  cfgrl_sync #(.W(1)) u_cs_sync (
    .clk_i   (mclk_i),
    .rst_n_i (reset_n_i),
    .d_i     (cs_n_i),
    .q_o     (cs_n_sync)
  );

  cfgrl_sync #(.W(2)) u_pin_sync (
    .clk_i   (mclk_i),
    .rst_n_i (reset_n_i),
    .d_i     (io_i[3:2]),
    .q_o     (pins_sync)
  );

  cfgrl_sync #(.W(1)) u_ev_sync (
    .clk_i   (mclk_i),
    .rst_n_i (reset_n_i),
    .d_i     (ev_flag_reg),
    .q_o     (ev_flag_sync)
  );

  cfgrl_sync #(.W($bits(cfgrl_pkg::cfgrl_pub_t))) u_pub_sync (
    .clk_i   (sck_i),
    .rst_n_i (1'b1),
    .d_i     (pub_mclk),
    .q_o     (pub_sck)
  );

  // Rising edge of the synchronised event flag marks a new event.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ev_seen_reg <= 1'b0;
    end else begin
      ev_seen_reg <= ev_flag_sync;
    end
  end

  // The event word is stable for the whole rest of the frame.
  assign ev_word = ev_reg;

  // Reset pin acts only while it is not used as a data lane.
  assign hw_reset = !pins_sync[1] && !cfg_vol[`CFGRL_QUAD_BIT]; // RULE19

  // Protect level seen by the device; held at one in quad mode.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wp_level_o <= 1'b0;
    end else begin
      wp_level_o <= cfg_vol[`CFGRL_QUAD_BIT] | pins_sync[0]; // RULE19
    end
  end

  // =====================================================================
  // Register bank and its visible settings.
  cfgrl_reg_bank u_bank (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .hw_reset_i  (hw_reset),
    .idle_i      (cs_n_sync),
    .ev_valid_i  (ev_flag_sync && !ev_seen_reg),
    .ev_i        (ev_word),
    .cfg_o       (cfg_vol),
    .crc_abort_o (crc_abort_o),
    .pub_o       (pub_mclk)
  );

  // Copies of the volatile settings for the rest of the chip.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      latency_code_o <= 4'h0;
      quad_enable_o  <= 1'b0;
    end else begin
      latency_code_o <= cfg_vol[`CFGRL_MLC_MSB:`CFGRL_MLC_LSB]; // RULE11
      quad_enable_o  <= cfg_vol[`CFGRL_QUAD_BIT]; // RULE18
    end
  end

endmodule : cfgrl_top

`default_nettype wire

// file: verification/cfgrl_sva.sv
/* Checker on the ports of cfgrl_top.
   Assumes the bind below attaches it to each cfgrl_top. */
`timescale 1ns/1ns
`default_nettype none
module cfgrl_sva (
  input wire logic       mclk_i,
  input wire logic       reset_n_i,
  input wire logic       sck_i,
  input wire logic       cs_n_i,
  input wire logic [3:0] io_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o,
  input wire logic [3:0] latency_code_o,
  input wire logic       quad_enable_o,
  input wire logic       wp_level_o,
  input wire logic       crc_abort_o
);
  logic [5:0] cnt;
  logic [7:0] op;
  logic [3:0] lat;
  // ==================================================
  // Frame tracking.
  // Counts link edges in a frame; select high clears it.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) cnt <= 6'h00;
    else if (cnt != 6'h3f) cnt <= cnt + 6'h01;
  end
  // Keeps the opcode and the latency in force at frame start.
  always_ff @(posedge sck_i) begin
    if (cnt < 6'h08) op <= {op[6:0], io_i[0]};
    if (cnt == 6'h00) lat <= latency_code_o;
  end
  sequence s_op(o);
    cnt == 6'h07 && {op[6:0], io_i[0]} == o;
  endsequence
  // ==================================================
  // Assertions.
  a_rst_clear:
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      $rose(reset_n_i) |-> !crc_abort_o && latency_code_o == 4'h0)
      else $error("rst");
  a_wp_quad:
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      quad_enable_o && $past(quad_enable_o) |-> wp_level_o) else $error("wp");
  a_oe_idle:
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      cs_n_i && $past(cs_n_i) |-> io_oe_o == 4'h0) else $error("oe idle");
  a_oe_legal:
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("oe value");
  a_quad_lanes:
    assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      io_oe_o == 4'hf |-> quad_enable_o) else $error("quad oe");
  a_rdcfg_oe:
    assert property (@(posedge sck_i) disable iff (cs_n_i)
      s_op(8'h35) |=> io_oe_o == 4'h2) else $error("cfg read oe");
  a_dummy_quiet:
    assert property (@(posedge sck_i) disable iff (cs_n_i) op == 8'h03 && cnt
      > 6'h07 && cnt < 6'h20 + {2'h0, lat} |-> io_oe_o == 4'h0)
      else $error("d");
  a_data_start:
    assert property (@(posedge sck_i) disable iff (cs_n_i) op == 8'h03 &&
      cnt == 6'h20 + {2'h0, lat} |-> io_oe_o == 4'h2) else $error("late");
endmodule : cfgrl_sva
bind cfgrl_top cfgrl_sva cfgrl_sva_inst (.mclk_i, .reset_n_i, .sck_i,
  .cs_n_i, .io_i, .io_o, .io_oe_o, .latency_code_o, .quad_enable_o,
  .wp_level_o, .crc_abort_o);
`default_nettype wire

// file: verification/cfgrl_host.sv
/* Host controller model driving the serial link in mode 0.
   Assumes the bench resolves each data line from both drivers. */
`timescale 1ns/1ns
`default_nettype none
module cfgrl_host (
  output logic       sck_o,
  output logic       cs_n_o,
  output logic [1:0] io_o,
  input  wire logic  miso_i
);
  // Link idles with the clock still and select high; a select pulse
  // at start clears the link logic.
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b0;
    io_o = 2'h1;
    #1 cs_n_o = 1'b1;
  end
  // ==================================================
  // One frame: opcode, address, data, dummy and read edges.
  task automatic frame(input logic [7:0] o, input logic [47:0] a,
    input int na, input logic [7:0] d, input int nd, nr, nq,
    output logic [7:0] q);
    q = 8'h00;
    #32 cs_n_o = 1'b0;
    for (int i = 0; i < 8 + na + nd + nr + nq; i++) begin
      // Released lines toggle so a stale level never looks valid.
      io_o[0] = i < 8 ? o[7 - i] : i < 8 + na ? a[55 - i] :
                i < 8 + na + nd ? d[15 + na - i] : ~io_o[0];
      io_o[1] = ~io_o[1];
      #32 sck_o = 1'b1;
      if (i >= 8 + na + nd + nr) q = {q[6:0], miso_i};
      #32 sck_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    #300;
  endtask : frame
endmodule : cfgrl_host
`default_nettype wire

// file: verification/config_register_latency_ctrl_tb.sv
/* Self-checking bench for cfgrl_top driven by the host model.
   Assumes the design, checker and host model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module config_register_latency_ctrl_tb;
  logic mclk = 1'b0, reset_n = 1'b0, rst_pin_n = 1'b1, wp_pin = 1'b0;
  logic sck, cs_n, quad, wp, crc_abort_flag;
  logic [1:0] hio;
  logic [3:0] io, io_o, io_oe, lat;
  logic [7:0] q;
  int fail_count = 0, total_checks = 0;
  // Written byte beside the byte it should read back as.
  logic [15:0] rows [4] = '{16'hf0f0, 16'h6d60, 16'h0f02, 16'h0000};
  // Each line shows the device where it drives, else the host side.
  assign io = (io_oe & io_o) | (~io_oe & {rst_pin_n, wp_pin, hio});
  cfgrl_top cfgrl_top_inst (.mclk_i(mclk), .reset_n_i(reset_n),
    .sck_i(sck), .cs_n_i(cs_n), .io_i(io), .io_o(io_o), .io_oe_o(io_oe),
    .latency_code_o(lat), .quad_enable_o(quad), .wp_level_o(wp),
    .crc_abort_o(crc_abort_flag));
  cfgrl_host cfgrl_host_inst (.sck_o(sck), .cs_n_o(cs_n), .io_o(hio),
    .miso_i(io[1]));
  initial forever #10 mclk = ~mclk;
  // Stops a hung run.
  initial begin
    #1000000 fail_count++;
    report_and_stop;
  end
  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic fr(input logic [7:0] o, input logic [47:0] a, input int na,
    input logic [7:0] d, input int nd, nr, nq);
    cfgrl_host_inst.frame(o, a, na, d, nd, nr, nq, q);
  endtask : fr
  // Write enable first, then the any-register write.
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    fr(8'h06, 48'h0, 0, 8'h00, 0, 0, 0);
    fr(8'h71, {a, 24'h0}, 24, d, 8, 0, 0);
  endtask : wr
  task automatic rd(input logic [7:0] o, input logic [23:0] a, input int nr);
    fr(o, {a, 24'h0}, o == 8'h35 ? 0 : 24, 8'h00, 0, nr, 8);
  endtask : rd
  // ==================================================
  // Main sequence: table rows, then hand-written cases.
  initial begin
    repeat (8) @(posedge mclk);
    #2 reset_n = 1'b1;
    repeat (8) @(posedge mclk);
    `CHK({lat, crc_abort_flag}, 5'h00);
    for (int i = 0; i < 4; i++) begin
      wr(24'h070002, rows[i][15:8]);
      `CHK(lat, rows[i][7:4]);
      `CHK({quad, wp}, {2{rows[i][1]}});
      rd(8'h35, 24'h0, 0);
      `CHK(q, rows[i][7:0]);
      rd(rows[i][1] ? 8'h6b : 8'h03, 24'h0000a5, int'(rows[i][7:4]));
      `CHK(q, rows[i][1] ? 8'haa : 8'ha5);
    end
    wr(24'h000002, 8'h51);
    `CHK(lat, 4'h5);
    wr(24'h070002, 8'h3d);
    rd(8'h65, 24'h000002, 0);
    `CHK(q, 8'h30);
    @(posedge mclk) #2 rst_pin_n = 1'b0;
    repeat (10) @(posedge mclk);
    #2 rst_pin_n = 1'b1;
    repeat (10) @(posedge mclk);
    rd(8'h65, 24'h070002, 0);
    `CHK(q, 8'h50);
    fr(8'h71, {24'h070002, 24'h0}, 24, 8'h10, 8, 0, 0);
    `CHK(lat, 4'h5);
    fr(8'h5b, {24'h10, 24'h12}, 48, 8'h00, 0, 0, 0);
    rd(8'h65, 24'h000001, 0);
    `CHK(q, 8'h08);
    fr(8'h5b, {24'h10, 24'h13}, 48, 8'h00, 0, 0, 0);
    `CHK(crc_abort_flag, 1'b0);
    fr(8'h5b, {24'h10, 24'h12}, 48, 8'h00, 0, 0, 0);
    `CHK(crc_abort_flag, 1'b1);
    fr(8'h66, 48'h0, 0, 8'h00, 0, 0, 0);
    fr(8'h99, 48'h0, 0, 8'h00, 0, 0, 0);
    `CHK(crc_abort_flag, 1'b0);
    report_and_stop;
  end
endmodule : config_register_latency_ctrl_tb
`default_nettype wire
